// File: acs_top.sv
// converter control: wishbone registers, channel sequencing, triggers, limits, result
// How it works
// - scan mode converts exactly four inputs, channels 0 to 3, unless the test register selects a test source.
// - select mode converts one source picked by the channel register.
// - conversion-end interrupt fires after every conversion that passes the limit check, also in scan.
// - result register written on completion, interrupt raised at the same clock edge.
// - result readable as 16-bit word or as 8-bit high byte.
// - resolution bit selects 8-bit or 10-bit conversion.
// - conversion clock is peripheral clock divided by three-bit select ratio.
// - operation mode bit picks one-shot/sequential; scan bit picks select/scan.
// - trigger mode field picks software or hardware; source field picks hardware trigger.
// - run bit gates conversion; comparator enable bit gates the comparator.
// - conversion-time field sets sampling length.
// - upper/lower limits; range bit chooses inside or outside for interrupt.
// - snooze bit lets conversions run while the cpu is stopped.
// - positive reference from two-bit select, negative from one bit.
// - test register two-bit field selects converter test source.
// - conversion clock runs only while the clock-enable bit is set.
// - clock-enable clear blocks writes to converter registers.
// - sequential mode keeps converting until software stops it; one-shot once.
// - 10-bit result sits left-justified in the 16-bit result word.
// - run bit reads as active during conversion, and during wait in wait mode.
//
// Decided for this implementation: the address map and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "acs_defs.svh"
module acs_top
	import acs_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic [3:0]  hw_trig,
	input  wire logic        cpu_stopped,
	input  wire logic        comp_high,
	output logic      [9:0]  dac_code,
	output logic      [4:0]  src_sel,
	output logic      [1:0]  pos_ref_sel,
	output logic             neg_ref_sel,
	output logic             comparator_on,
	output logic             conv_end_irq
);
	acs_conv_if cif ();

	logic [7:0]  mode0, next_mode0;
	logic [7:0]  mode1, next_mode1;
	logic [7:0]  mode2, next_mode2;
	logic [7:0]  upper, next_upper;
	logic [7:0]  lower, next_lower;
	logic [4:0]  chan, next_chan;
	logic [1:0]  test, next_test;
	logic        per_en, next_per_en;
	logic [9:0]  result, next_result;
	logic [31:0] dat, next_dat;
	logic        ack, next_ack;
	logic        irq, next_irq;
	logic        start, next_start;
	logic [4:0]  src, next_src;
	logic [1:0]  idx, next_idx;
	logic [3:0]  stab, next_stab;
	acs_seq_type state, next_state;
	logic        req, wr, can_run, trig, in_range, abort;
	logic [1:0]  tmode;

	// source code for a conversion; test mode overrides the mux
	function automatic logic [4:0] pick_src(input logic scan, input logic [1:0] i,
		input logic [4:0] ch, input logic [1:0] tsel);
		if (tsel == `ACS_TEST_NEG) begin
			pick_src = `ACS_SRC_TEST_NEG;
		end else if (tsel == `ACS_TEST_POS) begin
			pick_src = `ACS_SRC_TEST_POS;
		end else if (scan) begin
			pick_src = {3'h0, i};
		end else begin
			pick_src = ch;
		end
	endfunction

	function automatic logic [31:0] read_word(input logic [7:0] a);
		case (a)
			`ACS_OFF_MODE0:     read_word = {24'h000000, mode0};
			`ACS_OFF_MODE1:     read_word = {24'h000000, mode1};
			`ACS_OFF_MODE2:     read_word = {24'h000000, mode2};
			`ACS_OFF_RESULT:    read_word = {16'h0000, result, `ACS_JUSTIFY_PAD};
			`ACS_OFF_RESULT_HI: read_word = {24'h000000, result[9:2]};
			`ACS_OFF_UPPER:     read_word = {24'h000000, upper};
			`ACS_OFF_LOWER:     read_word = {24'h000000, lower};
			`ACS_OFF_CHANNEL:   read_word = {27'h0000000, chan};
			`ACS_OFF_TEST:      read_word = {30'h00000000, test};
			`ACS_OFF_PER_EN:    read_word = {26'h0000000, per_en, 5'h00};
			default:            read_word = 32'h00000000;
		endcase
	endfunction

	always_comb begin
		next_mode0  = mode0;
		next_mode1  = mode1;
		next_mode2  = mode2;
		next_upper  = upper;
		next_lower  = lower;
		next_chan   = chan;
		next_test   = test;
		next_per_en = per_en;
		next_result = result;
		next_dat    = dat;
		next_irq    = 1'b0;
		next_start  = 1'b0;
		next_src    = src;
		next_idx    = idx;
		next_stab   = stab;
		next_state  = state;
		abort       = 1'b0;
		req         = wb_cyc_i && wb_stb_i && !ack;
		next_ack    = req;
		// write lands at the edge where the master sees ack, not at the request edge
		wr          = wb_cyc_i && wb_stb_i && ack && wb_we_i && wb_sel_i[0];
		tmode       = mode1[`ACS_M1_TRIG_HI:`ACS_M1_TRIG_LO];
		trig        = hw_trig[mode1[`ACS_M1_TSRC_HI:`ACS_M1_TSRC_LO]];
		can_run     = per_en && mode0[`ACS_M0_CMP_EN]
			&& (!cpu_stopped || mode2[`ACS_M2_SNOOZE]);
		in_range    = (lower <= cif.code[9:2]) && (cif.code[9:2] <= upper);
		if (req) begin
			next_dat = read_word(wb_adr_i);
		end
		// sequencer; a software write below may still override the run bit
		case (state)
			ACS_IDLE: begin
				if (tmode == `ACS_TRIG_HW_WAIT) begin
					if (trig && can_run) begin
						next_mode0[`ACS_M0_RUN] = 1'b1;
						next_stab  = `ACS_STAB_TICKS;
						next_state = ACS_STAB;
					end
				end else if (mode0[`ACS_M0_RUN] && can_run) begin
					next_idx = 2'h0;
					if (tmode == `ACS_TRIG_HW_NOWAIT) begin
						next_state = ACS_STANDBY;
					end else begin
						next_start = 1'b1;
						next_src   = pick_src(mode1[`ACS_M1_SCAN], 2'h0, chan, test);
						next_state = ACS_CONV;
					end
				end
			end
			ACS_STANDBY: begin
				if (trig) begin
					next_start = 1'b1;
					next_src   = pick_src(mode1[`ACS_M1_SCAN], idx, chan, test);
					next_state = ACS_CONV;
				end
			end
			ACS_STAB: begin
				// power settle wait counted in conversion clocks
				if (cif.tick && stab == 4'h1) begin
					next_idx   = 2'h0;
					next_start = 1'b1;
					next_src   = pick_src(mode1[`ACS_M1_SCAN], 2'h0, chan, test);
					next_state = ACS_CONV;
				end else if (cif.tick) begin
					next_stab = stab - 4'h1;
				end
			end
			ACS_CONV: begin
				if (cif.done) begin
					next_result = cif.code;
					// only one result holds; an unread one is simply replaced
					next_irq = mode2[`ACS_M2_RANGE] ? !in_range : in_range;
					if (mode1[`ACS_M1_SCAN] && idx != `ACS_SCAN_LAST) begin
						next_idx   = idx + 2'h1;
						next_start = 1'b1;
						next_src   = pick_src(1'b1, idx + 2'h1, chan, test);
					end else if (mode0[`ACS_M0_OPMODE]) begin
						next_idx   = 2'h0;
						next_start = 1'b1;
						next_src   = pick_src(mode1[`ACS_M1_SCAN], 2'h0, chan, test);
					end else if (tmode == `ACS_TRIG_HW_NOWAIT) begin
						next_idx   = 2'h0;
						next_state = ACS_STANDBY;
					end else begin
						next_mode0[`ACS_M0_RUN] = 1'b0;
						next_state = ACS_IDLE;
					end
				end
			end
			default: next_state = ACS_IDLE;
		endcase
		if (state != ACS_IDLE && (!mode0[`ACS_M0_RUN] || !can_run)) begin
			abort      = 1'b1;
			next_start = 1'b0;
			next_state = ACS_IDLE;
		end
		if (wr && wb_adr_i == `ACS_OFF_PER_EN) begin
			next_per_en = wb_dat_i[`ACS_PER_CLKEN];
		end else if (wr && per_en) begin
			case (wb_adr_i)
				`ACS_OFF_MODE0: next_mode0 = wb_dat_i[7:0];
				`ACS_OFF_MODE1: next_mode1 = wb_dat_i[7:0];
				`ACS_OFF_MODE2: next_mode2 = wb_dat_i[7:0];
				`ACS_OFF_UPPER: next_upper = wb_dat_i[7:0];
				`ACS_OFF_LOWER: next_lower = wb_dat_i[7:0];
				`ACS_OFF_CHANNEL: next_chan = wb_dat_i[4:0];
				`ACS_OFF_TEST:  next_test  = wb_dat_i[1:0];
				default: next_per_en = per_en;
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			mode0  <= 8'h00;
			mode1  <= 8'h00;
			mode2  <= 8'h00;
			upper  <= `ACS_UPPER_RESET;
			lower  <= `ACS_LOWER_RESET;
			chan   <= 5'h00;
			test   <= 2'h0;
			per_en <= 1'b0;
			result <= 10'h000;
			dat    <= 32'h00000000;
			ack    <= 1'b0;
			irq    <= 1'b0;
			start  <= 1'b0;
			src    <= 5'h00;
			idx    <= 2'h0;
			stab   <= 4'h0;
			state  <= ACS_IDLE;
		end else begin
			mode0  <= next_mode0;
			mode1  <= next_mode1;
			mode2  <= next_mode2;
			upper  <= next_upper;
			lower  <= next_lower;
			chan   <= next_chan;
			test   <= next_test;
			per_en <= next_per_en;
			result <= next_result;
			dat    <= next_dat;
			ack    <= next_ack;
			irq    <= next_irq;
			start  <= next_start;
			src    <= next_src;
			idx    <= next_idx;
			stab   <= next_stab;
			state  <= next_state;
		end
	end

	assign cif.start     = start;
	assign cif.abort     = abort;
	assign cif.res8      = mode2[`ACS_M2_RES8];
	assign cif.time_mode = mode0[`ACS_M0_TIME_HI:`ACS_M0_TIME_LO];
	assign cif.div_sel   = mode0[`ACS_M0_DIV_HI:`ACS_M0_DIV_LO];
	assign cif.clk_en    = per_en;
	assign cif.comp_high = comp_high;

	acs_sar_core u_core (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.cif     (cif)
	);

	assign wb_dat_o      = dat;
	assign wb_ack_o      = ack;
	assign dac_code      = cif.dac;
	assign src_sel       = src;
	assign pos_ref_sel   = mode2[`ACS_M2_PREF_HI:`ACS_M2_PREF_LO];
	assign neg_ref_sel   = mode2[`ACS_M2_NREF];
	assign comparator_on = mode0[`ACS_M0_CMP_EN];
	assign conv_end_irq  = irq;

	sequence bus_req_s;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence conv_end_s;
		state == ACS_CONV && cif.done;
	endsequence
	ack_timing_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		bus_req_s |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus ack not a single cycle after request");
	irq_cause_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		conv_end_irq |-> $past(cif.done) && $past(state) == ACS_CONV)
		else $error("interrupt without a conversion end");
	result_store_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		conv_end_s |=> result == $past(cif.code))
		else $error("result not stored at conversion end");
	write_lock_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!per_en && wb_adr_i == `ACS_OFF_MODE1 |=> $stable(mode1))
		else $error("register changed while clock supply off");
	scan_order_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		conv_end_s and (mode1[`ACS_M1_SCAN] && idx != `ACS_SCAN_LAST
		&& mode0[`ACS_M0_RUN] && can_run) |=> idx == $past(idx) + 2'h1
		&& start && src_sel == {3'h0, idx})
		else $error("scan did not step to next channel");
	scan_source_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		start && mode1[`ACS_M1_SCAN] && test == 2'h0 |-> src_sel[4:2] == 3'h0)
		else $error("scan converted a channel outside 0 to 3");
	oneshot_stop_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		conv_end_s and (!mode0[`ACS_M0_OPMODE] && tmode == `ACS_TRIG_SW
		&& (!mode1[`ACS_M1_SCAN] || idx == `ACS_SCAN_LAST) && can_run && !wr)
		|=> !mode0[`ACS_M0_RUN] && state == ACS_IDLE)
		else $error("one-shot conversion did not stop");
	range_irq_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		conv_end_s and (mode2[`ACS_M2_RANGE] == in_range) |=> !conv_end_irq)
		else $error("interrupt raised against limit check");
endmodule
`default_nettype wire

// File: acs_defs.svh
// register map, field positions, reset values and timing counts of the converter control
`ifndef ACS_DEFS_SVH
`define ACS_DEFS_SVH
`define ACS_OFF_MODE0      8'h00
`define ACS_OFF_MODE1      8'h04
`define ACS_OFF_MODE2      8'h08
`define ACS_OFF_RESULT     8'h0C
`define ACS_OFF_RESULT_HI  8'h10
`define ACS_OFF_UPPER      8'h14
`define ACS_OFF_LOWER      8'h18
`define ACS_OFF_CHANNEL    8'h1C
`define ACS_OFF_TEST       8'h20
`define ACS_OFF_PER_EN     8'h24
`define ACS_M0_RUN         7
`define ACS_M0_OPMODE      6
`define ACS_M0_DIV_HI      5
`define ACS_M0_DIV_LO      3
`define ACS_M0_TIME_HI     2
`define ACS_M0_TIME_LO     1
`define ACS_M0_CMP_EN      0
`define ACS_M1_TRIG_HI     7
`define ACS_M1_TRIG_LO     6
`define ACS_M1_SCAN        5
`define ACS_M1_TSRC_HI     1
`define ACS_M1_TSRC_LO     0
`define ACS_M2_PREF_HI     7
`define ACS_M2_PREF_LO     6
`define ACS_M2_NREF        5
`define ACS_M2_RANGE       3
`define ACS_M2_SNOOZE      2
`define ACS_M2_RES8        0
`define ACS_PER_CLKEN      5
`define ACS_TRIG_SW        2'h0
`define ACS_TRIG_HW_NOWAIT 2'h2
`define ACS_TRIG_HW_WAIT   2'h3
`define ACS_UPPER_RESET    8'hFF
`define ACS_LOWER_RESET    8'h00
`define ACS_SRC_AMP_OUT    5'h08
`define ACS_SRC_TEST_NEG   5'h1A
`define ACS_SRC_TEST_POS   5'h1B
`define ACS_TEST_NEG       2'h2
`define ACS_TEST_POS       2'h3
`define ACS_SCAN_LAST      2'h3
`define ACS_STAB_TICKS     4'h8
`define ACS_SAMP_LV0       4'h7
`define ACS_SAMP_LV1       4'h5
`define ACS_SAMP_LV2       4'h3
`define ACS_SAMP_LV3       4'h2
`define ACS_MSB_INDEX      4'h9
`define ACS_LSB10_INDEX    4'h0
`define ACS_LSB8_INDEX     4'h2
`define ACS_JUSTIFY_PAD    6'h00
`endif

// File: acs_pkg.sv
// types shared by the converter control modules
`default_nettype none
package acs_pkg;
	typedef enum logic [1:0] {
		ACS_IDLE    = 2'b00,
		ACS_STANDBY = 2'b01,
		ACS_STAB    = 2'b10,
		ACS_CONV    = 2'b11
	} acs_seq_type;
	typedef enum logic [1:0] {
		ACS_SAR_IDLE = 2'b00,
		ACS_SAR_SAMP = 2'b01,
		ACS_SAR_BITS = 2'b10
	} acs_sar_type;
endpackage
`default_nettype wire

// File: acs_conv_if.sv
// link between the sequencer and the approximation core
`timescale 1ns/1ps
`default_nettype none
interface acs_conv_if;
	logic       start;
	logic       abort;
	logic       res8;
	logic [1:0] time_mode;
	logic [2:0] div_sel;
	logic       clk_en;
	logic       comp_high;
	logic       tick;
	logic       busy;
	logic       done;
	logic [9:0] code;
	logic [9:0] dac;
	modport seq  (output start, abort, res8, time_mode, div_sel, clk_en, comp_high,
		input tick, busy, done, code, dac);
	modport core (input start, abort, res8, time_mode, div_sel, clk_en, comp_high,
		output tick, busy, done, code, dac);
endinterface
`default_nettype wire

// File: acs_sar_core.sv
// conversion clock divider and successive-approximation engine
`timescale 1ns/1ps
`default_nettype none
`include "acs_defs.svh"
module acs_sar_core
	import acs_pkg::*;
(
	input  wire logic ref_clk,
	input  wire logic sys_rst,
	acs_conv_if.core  cif
);
	logic [5:0]  div_cnt, next_div_cnt;
	logic        tick, next_tick;
	acs_sar_type state, next_state;
	logic [3:0]  samp_cnt, next_samp_cnt;
	logic [3:0]  bitn, next_bitn;
	logic        res8, next_res8;
	logic [9:0]  code, next_code;
	logic [9:0]  dac, next_dac;
	logic        done, next_done;
	logic [9:0]  kept;

	// divide ratios 64,32,16,8,6,5,4,2 as terminal counts
	function automatic logic [5:0] div_last(input logic [2:0] sel);
		case (sel)
			3'h0: div_last = 6'h3F;
			3'h1: div_last = 6'h1F;
			3'h2: div_last = 6'h0F;
			3'h3: div_last = 6'h07;
			3'h4: div_last = 6'h05;
			3'h5: div_last = 6'h04;
			3'h6: div_last = 6'h03;
			default: div_last = 6'h01;
		endcase
	endfunction

	function automatic logic [9:0] bit_mask(input logic [3:0] n);
		bit_mask = 10'(10'h001 << n);
	endfunction

	always_comb begin
		next_div_cnt  = div_cnt;
		next_tick     = 1'b0;
		next_state    = state;
		next_samp_cnt = samp_cnt;
		next_bitn     = bitn;
		next_res8     = res8;
		next_code     = code;
		next_dac      = dac;
		next_done     = 1'b0;
		kept          = cif.comp_high ? dac : (dac & ~bit_mask(bitn));
		// gated clock: no tick at all while supply is off
		if (!cif.clk_en) begin
			next_div_cnt = 6'h00;
		end else if (div_cnt >= div_last(cif.div_sel)) begin
			next_div_cnt = 6'h00;
			next_tick    = 1'b1;
		end else begin
			next_div_cnt = div_cnt + 6'h01;
		end
		case (state)
			ACS_SAR_IDLE: begin
				if (cif.start) begin
					next_state = ACS_SAR_SAMP;
					next_res8  = cif.res8;
					case (cif.time_mode)
						2'h0: next_samp_cnt = `ACS_SAMP_LV0;
						2'h1: next_samp_cnt = `ACS_SAMP_LV1;
						2'h2: next_samp_cnt = `ACS_SAMP_LV2;
						default: next_samp_cnt = `ACS_SAMP_LV3;
					endcase
				end
			end
			ACS_SAR_SAMP: begin
				if (tick && samp_cnt == 4'h0) begin
					next_state = ACS_SAR_BITS;
					next_bitn  = `ACS_MSB_INDEX;
					next_dac   = bit_mask(`ACS_MSB_INDEX);
				end else if (tick) begin
					next_samp_cnt = samp_cnt - 4'h1;
				end
			end
			ACS_SAR_BITS: begin
				if (tick && bitn == (res8 ? `ACS_LSB8_INDEX : `ACS_LSB10_INDEX)) begin
					next_code  = kept;
					next_dac   = kept;
					next_done  = 1'b1;
					next_state = ACS_SAR_IDLE;
				end else if (tick) begin
					next_bitn = bitn - 4'h1;
					next_dac  = kept | bit_mask(bitn - 4'h1);
				end
			end
			default: next_state = ACS_SAR_IDLE;
		endcase
		if (cif.abort) begin
			next_state = ACS_SAR_IDLE;
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			div_cnt  <= 6'h00;
			tick     <= 1'b0;
			state    <= ACS_SAR_IDLE;
			samp_cnt <= 4'h0;
			bitn     <= 4'h0;
			res8     <= 1'b0;
			code     <= 10'h000;
			dac      <= 10'h000;
			done     <= 1'b0;
		end else begin
			div_cnt  <= next_div_cnt;
			tick     <= next_tick;
			state    <= next_state;
			samp_cnt <= next_samp_cnt;
			bitn     <= next_bitn;
			res8     <= next_res8;
			code     <= next_code;
			dac      <= next_dac;
			done     <= next_done;
		end
	end

	assign cif.tick = tick;
	assign cif.busy = (state != ACS_SAR_IDLE);
	assign cif.done = done;
	assign cif.code = code;
	assign cif.dac  = dac;

	clk_gate_tick_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!cif.clk_en |=> !tick)
		else $error("conversion clock ticked with supply off");
	res8_low_bits_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		done && res8 |-> code[1:0] == 2'h0)
		else $error("8-bit result has low bits set");
endmodule
`default_nettype wire

// File: acs_analog_model.sv
// analog side model: per-source input levels and the comparator decision
`timescale 1ns/1ps
`default_nettype none
module acs_analog_model (
	input  wire logic       ref_clk,
	input  wire logic       comparator_on,
	input  wire logic [4:0] src_sel,
	input  wire logic [9:0] dac_code,
	output logic            comp_high
);
	logic [9:0] level [32];
	logic       junk;
	initial begin
		junk = 1'b0;
		for (int i = 0; i < 32; i++) begin
			level[i] = 10'h2A5 ^ 10'(i * 37);
		end
	end
	// comparator off gives no decision, so a toggling level instead of a held one
	always @(posedge ref_clk) begin
		junk <= ~junk;
	end
	assign comp_high = comparator_on ? (level[src_sel] >= dac_code) : junk;
endmodule
`default_nettype wire

// File: tb_top.sv
// self-checking bench for the converter control
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
	$display("MISMATCH t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module tb_top;
	logic        ref_clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        wb_cyc = 1'b0;
	logic        wb_stb = 1'b0;
	logic        wb_we = 1'b0;
	logic [7:0]  wb_adr = 8'h00;
	logic [31:0] wb_dat = 32'h0;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic [3:0]  hw_trig = 4'h0;
	logic        cpu_stopped = 1'b0;
	logic        comp_high;
	logic [9:0]  dac_code;
	logic [4:0]  src_sel;
	logic [1:0]  pos_ref_sel;
	logic        neg_ref_sel;
	logic        comparator_on;
	logic        conv_end_irq;
	logic [9:0]  e;
	logic [31:0] q;
	int          bad_count = 0;
	int          samples_checked = 0;
	int          n;
	int          t2;
	int          t4;
	logic [4:0]  codes [4] = '{5'h00, 5'h10, 5'h16, 5'h08};

	always #25 ref_clk = ~ref_clk;

	acs_top DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'h1), .wb_dat_i(wb_dat),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .hw_trig(hw_trig),
		.cpu_stopped(cpu_stopped), .comp_high(comp_high), .dac_code(dac_code),
		.src_sel(src_sel), .pos_ref_sel(pos_ref_sel), .neg_ref_sel(neg_ref_sel),
		.comparator_on(comparator_on), .conv_end_irq(conv_end_irq));
	acs_analog_model ana (.ref_clk(ref_clk), .comparator_on(comparator_on),
		.src_sel(src_sel), .dac_code(dac_code), .comp_high(comp_high));

	function automatic logic [9:0] lv(input logic [4:0] s);
		return 10'h2A5 ^ 10'(s * 37);
	endfunction
	task automatic stop_test();
		if (bad_count == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic fail_out();
		bad_count++;
		stop_test();
	endtask
	// request held until ack is sampled high, released only at that edge
	task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge ref_clk);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= a;
		wb_dat <= d;
		do begin
			@(posedge ref_clk);
			k++;
		end while (wb_ack_o !== 1'b1 && k < 20);
		if (k >= 20) fail_out();
		q = wb_dat_o;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] x);
		bus(1'b0, a, 32'h0);
		`CHK(q, x)
	endtask
	task automatic wait_irq(output int c);
		c = 0;
		do begin
			@(posedge ref_clk);
			c++;
		end while (conv_end_irq !== 1'b1 && c < 2000);
		if (c >= 2000) fail_out();
	endtask
	task automatic quiet(input int len);
		repeat (len) begin
			@(posedge ref_clk);
			`CHK(conv_end_irq, 1'b0)
		end
	endtask

	initial begin
		repeat (3) @(posedge ref_clk);
		sys_rst <= 1'b0;
		rd_chk(8'h14, 32'hFF);
		rd_chk(8'h18, 32'h00);
		rd_chk(8'h30, 32'h00);
		wr(8'h14, 32'h55);
		rd_chk(8'h14, 32'hFF);
		wr(8'h04, 32'hFF);
		rd_chk(8'h04, 32'h00);
		wr(8'h24, 32'h20);
		wr(8'h08, 32'h60);
		wr(8'h00, 32'h01);
		// the write lands at the ack edge itself, so let it settle
		@(posedge ref_clk);
		`CHK({pos_ref_sel, neg_ref_sel, comparator_on}, 4'b0111)
		foreach (codes[i]) begin
			wr(8'h1C, 32'(codes[i]));
			wr(8'h00, 32'hBF);
			wait_irq(t2);
			e = lv(codes[i]);
			`CHK(src_sel, codes[i])
			rd_chk(8'h0C, {16'h0, e, 6'h00});
			rd_chk(8'h10, {24'h0, e[9:2]});
			rd_chk(8'h00, 32'h3F);
			quiet(100);
		end
		wr(8'h00, 32'hB7);
		wait_irq(t4);
		`CHK((t4 - t2) inside {[22:30]}, 1'b1)
		wr(8'h00, 32'hB9);
		wait_irq(t4);
		`CHK((t4 - t2) inside {[8:12]}, 1'b1)
		// 8-bit mode only settles the top eight decisions
		wr(8'h08, 32'h61);
		wr(8'h1C, 32'h00);
		wr(8'h00, 32'hBF);
		wait_irq(n);
		e = lv(5'h00);
		rd_chk(8'h10, {24'h0, e[9:2]});
		rd_chk(8'h0C, {16'h0, e[9:2], 8'h00});
		wr(8'h08, 32'h60);
		wr(8'h14, 32'h20);
		wr(8'h18, 32'h10);
		wr(8'h00, 32'hBF);
		quiet(150);
		rd_chk(8'h0C, {16'h0, lv(5'h00), 6'h00});
		wr(8'h08, 32'h68);
		wr(8'h00, 32'hBF);
		wait_irq(n);
		wr(8'h14, 32'hFF);
		wr(8'h18, 32'h00);
		wr(8'h08, 32'h60);
		wr(8'h04, 32'h20);
		wr(8'h00, 32'hBF);
		for (int i = 0; i < 4; i++) begin
			wait_irq(n);
			rd_chk(8'h0C, {16'h0, lv(5'(i)), 6'h00});
		end
		quiet(150);
		wr(8'h04, 32'h00);
		wr(8'h00, 32'hFF);
		repeat (3) wait_irq(n);
		wr(8'h00, 32'h7F);
		quiet(150);
		wr(8'h00, 32'hBE);
		quiet(150);
		wr(8'h00, 32'h3F);
		wr(8'h00, 32'hBF);
		wr(8'h24, 32'h00);
		quiet(150);
		wr(8'h24, 32'h20);
		wr(8'h00, 32'h3F);
		wr(8'h04, 32'h82);
		wr(8'h00, 32'hBF);
		hw_trig <= 4'h1;
		quiet(100);
		hw_trig <= 4'h4;
		@(posedge ref_clk);
		hw_trig <= 4'h0;
		wait_irq(n);
		quiet(100);
		wr(8'h00, 32'h3F);
		wr(8'h04, 32'hC2);
		hw_trig <= 4'h4;
		@(posedge ref_clk);
		hw_trig <= 4'h0;
		rd_chk(8'h00, 32'hBF);
		wait_irq(n);
		rd_chk(8'h00, 32'h3F);
		wr(8'h04, 32'h00);
		cpu_stopped <= 1'b1;
		wr(8'h08, 32'h64);
		wr(8'h00, 32'hBF);
		wait_irq(n);
		wr(8'h08, 32'h60);
		wr(8'h00, 32'hBF);
		quiet(150);
		cpu_stopped <= 1'b0;
		wr(8'h00, 32'h3F);
		wr(8'h20, 32'h03);
		wr(8'h00, 32'hBF);
		wait_irq(n);
		`CHK(src_sel, 5'h1B)
		stop_test();
	end
endmodule
`default_nettype wire
